/* File: pkg/sfsp_cfg.svh */
`ifndef SFSP_CFG_SVH
`define SFSP_CFG_SVH
`define SFSP_ADDR_W 18
`define SFSP_DATA_W 32
`define SFSP_PAR_W 4
`define SFSP_LANES 4
`define SFSP_LANE_W 8
`define SFSP_BURST_W 2
`define SFSP_FIFO_DEPTH 16
`define SFSP_MEM_WORDS 262144
`endif

/* File: pkg/sfsp_pkg.sv */
`include "sfsp_cfg.svh"
package sfsp_pkg;
	typedef logic [`SFSP_ADDR_W-1:0] sfsp_addr_t;
	typedef logic [`SFSP_DATA_W-1:0] sfsp_data_t;
	typedef logic [`SFSP_PAR_W-1:0] sfsp_par_t;
	typedef logic [`SFSP_LANES-1:0] sfsp_lanes_t;
	typedef enum logic [2:0] {
		SFSP_IDLE  = 3'b001,
		SFSP_READ  = 3'b010,
		SFSP_WRITE = 3'b100
	} sfsp_phase_e;
	typedef struct packed {
		logic       write;
		sfsp_addr_t addr;
		sfsp_lanes_t lanes;
		sfsp_data_t data;
		sfsp_par_t  par;
	} sfsp_req_s;
endpackage

/* File: pkg/sfsp_if.sv */
`timescale 1ns/10ps
interface sfsp_if;
	import sfsp_pkg::*;
	logic        clock_qualify_n;
	logic        advance_or_load;
	logic        write_n;
	logic        chip_select_one_n;
	logic        chip_select_two;
	logic        chip_select_three_n;
	logic        output_enable_n;
	logic        sleep_request;
	logic        burst_order;
	sfsp_addr_t  addr;
	sfsp_lanes_t lane_write_n;
	sfsp_data_t  dq_ctl_out;
	logic        dq_ctl_oe;
	sfsp_par_t   parity_pins_ctl_out;
	sfsp_data_t  dq_mem_out;
	logic        dq_mem_oe;
	sfsp_par_t   parity_pins_mem_out;
	sfsp_data_t  dq;
	sfsp_par_t   parity_pins;
	assign dq          = dq_mem_oe ? dq_mem_out : dq_ctl_out;
	assign parity_pins = dq_mem_oe ? parity_pins_mem_out : parity_pins_ctl_out;
	modport mem (input clock_qualify_n, advance_or_load, write_n, chip_select_one_n, chip_select_two,
		chip_select_three_n, output_enable_n, sleep_request, burst_order, addr, lane_write_n, dq, parity_pins,
		output dq_mem_out, dq_mem_oe, parity_pins_mem_out);
	modport ctl (output clock_qualify_n, advance_or_load, write_n, chip_select_one_n, chip_select_two,
		chip_select_three_n, output_enable_n, sleep_request, burst_order, addr, lane_write_n,
		dq_ctl_out, dq_ctl_oe, parity_pins_ctl_out, input dq, parity_pins);
endinterface

/* File: core/sfsp_fifo.sv */
`timescale 1ns/10ps
module sfsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;
	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // sfsp_fifo

/* File: core/sfsp_mem.sv */
`timescale 1ns/10ps
`include "sfsp_cfg.svh"
module sfsp_mem (
	input  wire logic clk,
	input  wire logic rst_n,
	sfsp_if.mem       bus
);
	import sfsp_pkg::*;
	localparam int WW = `SFSP_DATA_W + `SFSP_PAR_W;
	// storage, one data and parity word per location
	logic [WW-1:0]              mem_q [`SFSP_MEM_WORDS];
	// access state
	logic [`SFSP_ADDR_W-1:0]    base_q;
	logic [`SFSP_BURST_W-1:0]   cnt_q;
	logic [`SFSP_BURST_W-1:0]   start_q;
	sfsp_phase_e                phase_q;
	logic                       write_q;
	logic                       asleep_q;
	sfsp_lanes_t                lanes_q;
	// pin decode
	logic [`SFSP_ADDR_W-1:0]    acc_addr;
	logic [`SFSP_ADDR_W-1:0]    nxt_addr;
	logic [`SFSP_BURST_W-1:0]   nxt_cnt;
	logic                       go;
	logic                       sel;
	logic                       load;
	logic                       advance;
	logic                       deselect;
	logic                       rd_next;
	logic                       first_out;
	logic                       commit;
	logic                       bypass;
	logic [WW-1:0]              rd_word;
	logic [WW-1:0]              wr_word;
	logic [WW-1:0]              out_word;

	function automatic logic [`SFSP_BURST_W-1:0] next_burst(input logic [`SFSP_BURST_W-1:0] c,
		input logic [`SFSP_BURST_W-1:0] s, input logic inter);
		logic [`SFSP_BURST_W-1:0] step;
		step = (c ^ s) + 2'h1;
		next_burst = inter ? (s ^ step) : (c + 2'h1);
	endfunction

	// location of one burst step inside its group
	function automatic logic [`SFSP_ADDR_W-1:0] group_addr(input logic [`SFSP_ADDR_W-1:0] base,
		input logic [`SFSP_BURST_W-1:0] low);
		group_addr = {base[`SFSP_ADDR_W-1:`SFSP_BURST_W], low};
	endfunction

	assign go        = !bus.clock_qualify_n && !bus.sleep_request && !asleep_q;
	assign sel       = !bus.chip_select_one_n && bus.chip_select_two && !bus.chip_select_three_n;
	assign load      = go && !bus.advance_or_load && sel;
	assign advance   = go && bus.advance_or_load && phase_q != SFSP_IDLE;
	assign deselect  = go && !bus.advance_or_load && !sel;
	assign acc_addr  = group_addr(base_q, cnt_q);
	assign nxt_cnt   = next_burst(cnt_q, start_q, bus.burst_order);
	assign nxt_addr  = load ? bus.addr : group_addr(base_q, nxt_cnt);
	assign rd_next   = load ? bus.write_n : advance && phase_q == SFSP_READ;
	assign first_out = load && phase_q == SFSP_IDLE;
	assign commit    = go && phase_q == SFSP_WRITE && write_q;
	// a read of the word being written this edge sees the new bytes
	assign bypass    = commit && nxt_addr == acc_addr;
	assign out_word  = bypass ? wr_word : mem_q[nxt_addr];

	// sleep state, first edge after wake ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			asleep_q <= 1'b0;
		end else begin
			asleep_q <= bus.sleep_request;
		end
	end

	// access phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= SFSP_IDLE;
		end else if (load) begin
			phase_q <= !bus.write_n ? SFSP_WRITE : SFSP_READ;
		end else if (deselect) begin
			phase_q <= SFSP_IDLE;
		end
	end

	// loaded address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= '0;
		end else if (load) begin
			base_q <= bus.addr;
		end
	end

	// burst start for interleaved order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= '0;
		end else if (load) begin
			start_q <= bus.addr[`SFSP_BURST_W-1:0];
		end
	end

	// write flag of the loaded access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_q <= 1'b0;
		end else if (load) begin
			write_q <= !bus.write_n;
		end
	end

	// burst counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= bus.addr[`SFSP_BURST_W-1:0];
		end else if (advance) begin
			cnt_q <= nxt_cnt;
		end
	end

	// byte selects for the following data phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lanes_q <= '1;
		end else if (go) begin
			lanes_q <= bus.lane_write_n;
		end
	end

	// write data lands one qualified cycle after its address
	always_comb begin
		rd_word = mem_q[acc_addr];
		for (int i = 0; i < `SFSP_LANES; i++) begin
			wr_word[i*`SFSP_LANE_W +: `SFSP_LANE_W] = lanes_q[i] ?
				rd_word[i*`SFSP_LANE_W +: `SFSP_LANE_W] : bus.dq[i*`SFSP_LANE_W +: `SFSP_LANE_W];
			wr_word[`SFSP_DATA_W + i] = lanes_q[i] ? rd_word[`SFSP_DATA_W + i] : bus.parity_pins[i];
		end
	end

	// array write
	always_ff @(posedge clk) begin
		if (commit) begin
			mem_q[acc_addr] <= wr_word;
		end
	end

	// flow-through read data, held while the clock is masked
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.dq_mem_out <= '0;
		end else if (go) begin
			bus.dq_mem_out <= out_word[`SFSP_DATA_W-1:0];
		end
	end

	// parity read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.parity_pins_mem_out <= '0;
		end else if (go) begin
			bus.parity_pins_mem_out <= out_word[WW-1:`SFSP_DATA_W];
		end
	end

	// read drivers, only in the data phase of a read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.dq_mem_oe <= 1'b0;
		end else if (go) begin
			bus.dq_mem_oe <= !bus.output_enable_n && rd_next && !first_out;
		end else if (bus.output_enable_n || bus.sleep_request) begin
			bus.dq_mem_oe <= 1'b0;
		end
	end
endmodule // sfsp_mem

/* File: core/sfsp_ctl.sv */
`timescale 1ns/10ps
`include "sfsp_cfg.svh"
module sfsp_ctl (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	sfsp_if.ctl                       bus,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire sfsp_pkg::sfsp_req_s  req,
	output logic                      rd_valid,
	output sfsp_pkg::sfsp_data_t      rd_data,
	input  wire logic                 burst_order
);
	import sfsp_pkg::*;
	localparam int RW = $bits(sfsp_req_s);
	logic       f_valid;
	logic       f_ready;
	logic [RW-1:0] f_data;
	sfsp_req_s  cur;
	logic [1:0] rd_pipe_q;
	sfsp_data_t wdata_q;
	sfsp_par_t  wpar_q;
	assign cur = sfsp_req_s'(f_data);
	assign f_ready = 1'b1;
	sfsp_fifo #(.WIDTH(RW), .DEPTH(`SFSP_FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (RW'(req)),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);
	// one load per request, never a burst advance
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.clock_qualify_n     <= 1'b0;
			bus.advance_or_load     <= 1'b0;
			bus.write_n             <= 1'b1;
			bus.chip_select_one_n   <= 1'b1;
			bus.chip_select_two     <= 1'b0;
			bus.chip_select_three_n <= 1'b1;
			bus.output_enable_n     <= 1'b1;
			bus.sleep_request       <= 1'b0;
			bus.burst_order         <= 1'b0;
			bus.addr                <= '0;
			bus.lane_write_n        <= '1;
			bus.dq_ctl_oe           <= 1'b0;
			bus.dq_ctl_out          <= '0;
			bus.parity_pins_ctl_out <= '0;
		end else begin
			bus.burst_order       <= burst_order;
			bus.advance_or_load   <= 1'b0;
			bus.chip_select_one_n <= !f_valid;
			bus.chip_select_two   <= f_valid;
			bus.chip_select_three_n <= !f_valid;
			bus.addr              <= cur.addr;
			bus.write_n           <= !(f_valid && cur.write);
			bus.lane_write_n      <= (f_valid && cur.write) ? ~cur.lanes : '1;
			bus.dq_ctl_oe         <= !bus.write_n;
			bus.output_enable_n   <= !(f_valid && !cur.write);
			bus.dq_ctl_out        <= wdata_q;
			bus.parity_pins_ctl_out <= wpar_q;
		end
	end
	// write data trails its address by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdata_q <= '0;
			wpar_q  <= '0;
		end else begin
			wdata_q <= cur.data;
			wpar_q  <= cur.par;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pipe_q <= '0;
			rd_valid  <= 1'b0;
			rd_data   <= '0;
		end else begin
			rd_pipe_q <= {rd_pipe_q[0], f_valid && !cur.write};
			rd_valid  <= rd_pipe_q[1];
			rd_data   <= bus.dq;
		end
	end
endmodule // sfsp_ctl

/* File: verification/sfsp_checker.sv */
`timescale 1ns/10ps
module sfsp_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clock_qualify_n,
	input wire logic advance_or_load,
	input wire logic write_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic dq_ctl_oe,
	input wire logic dq_mem_oe
);
	wire q = !clock_qualify_n && !sleep_request;
	wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	wire ld_wr = q && sel && !advance_or_load && !write_n;
	wire ld_rd = q && sel && !advance_or_load && write_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_no_contention: assert property (!(dq_mem_oe && dq_ctl_oe)) else $error("both ends drive");
	a_oe_floats: assert property (output_enable_n && $past(output_enable_n) |-> !dq_mem_oe)
		else $error("drive with enable high");
	a_deselect_float: assert property (q && !sel |=> !dq_mem_oe) else $error("drive when deselected");
	a_write_no_drive: assert property (ld_wr |=> !dq_mem_oe) else $error("drive in write data");
	a_write_data_next: assert property (ld_wr |=> dq_ctl_oe) else $error("write data late");
	a_data_has_cause: assert property (dq_ctl_oe |-> $past(ld_wr)) else $error("stray write data");
	a_first_masked: assert property (q && !sel ##1 ld_rd |=> !dq_mem_oe) else $error("first read driven");
	a_read_drives: assert property (q && sel ##1 ld_rd && !output_enable_n |=> dq_mem_oe)
		else $error("read not driven");
	a_load_after_off: assert property (!sel ##1 sel |-> !advance_or_load) else $error("advance after off");
	a_sleep_low: assert property (!sleep_request) else $error("sleep raised");
endmodule // sfsp_checker

/* File: verification/test_sync_flowthrough_sram_port.sv */
`timescale 1ns/10ps
module test_sync_flowthrough_sram_port;
	import sfsp_pkg::*;
	logic       clk = 0, rst_n = 0, req_valid = 0, req_ready, rd_valid, burst_order = 1;
	sfsp_req_s  req = '0;
	sfsp_data_t rd_data, mdl [int], exp_q [$];
	int         num_errors = 0, total_checks = 0;
	always #10 clk = ~clk;
	sfsp_if bus_if ();
	sfsp_mem sfsp_mem_i (.clk(clk), .rst_n(rst_n), .bus(bus_if));
	sfsp_ctl sfsp_ctl_i (.clk(clk), .rst_n(rst_n), .bus(bus_if), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rd_valid(rd_valid), .rd_data(rd_data), .burst_order(burst_order));
	sfsp_checker sfsp_checker_i (.clk(clk), .rst_n(rst_n), .clock_qualify_n(bus_if.clock_qualify_n),
		.advance_or_load(bus_if.advance_or_load), .write_n(bus_if.write_n),
		.chip_select_one_n(bus_if.chip_select_one_n), .chip_select_two(bus_if.chip_select_two),
		.chip_select_three_n(bus_if.chip_select_three_n), .output_enable_n(bus_if.output_enable_n),
		.sleep_request(bus_if.sleep_request), .dq_ctl_oe(bus_if.dq_ctl_oe), .dq_mem_oe(bus_if.dq_mem_oe));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function sfsp_data_t merge(sfsp_data_t o, sfsp_data_t n, sfsp_lanes_t l);
		for (int i = 0; i < 4; i++)
			if (l[i]) o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction
	task send(input logic w, input sfsp_addr_t a, input sfsp_lanes_t l, input sfsp_data_t d);
		@(negedge clk);
		while (!req_ready) @(negedge clk);
		req_valid = 1;
		req = '{w, a, l, d, 4'hf};
		if (w) mdl[a] = merge(mdl[a], d, l);
		else exp_q.push_back(mdl[a]);
		@(posedge clk);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge clk)
		if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
	initial begin
		sfsp_addr_t  a;
		sfsp_lanes_t l;
		int          n;
		int          k;
		void'($urandom(32'ha3b23810));
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n = 1;
		for (int i = 0; i < 20; i++) begin
			a = i == 0 ? '0 : i == 1 ? '1 : $urandom;
			l = i == 0 ? 4'h0 : i == 1 ? 4'h5 : $urandom;
			send(1, a, 4'hf, $urandom);
			send(1, a, l, $urandom);
			send(0, a, 4'h0, '0);
			send(0, a, 4'h0, '0);
			@(negedge clk) req_valid = 0;
			burst_order = i[0];
		end
		for (n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge clk);
		check(exp_q.size(), 0);
		k = 0;
		for (n = 0; n < 16; n++) begin
			k += int'(req_ready === 1'b1);
			send(1, sfsp_addr_t'(n), 4'hf, $urandom);
		end
		for (n = 0; n < 16; n++) send(0, sfsp_addr_t'(n), 4'h0, '0);
		@(negedge clk) req_valid = 0;
		check(k, 16);
		for (n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge clk);
		check(exp_q.size(), 0);
		@(negedge clk);
		check({31'h0, rd_valid}, 0);
		print_verdict;
	end
	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end
endmodule // test_sync_flowthrough_sram_port
